//--- inc/dfcr_pkg.sv
// =====================================================================
// Data flag condition register constants and carriers
package dfcr_pkg;

    // =================================================================
    // Register layout
    localparam int DFCR_W      = 64;
    localparam int PROD_LO     = 3;
    localparam int MASK_LO     = 19;
    localparam int FLAG_LO     = 35;
    localparam int FIELD_N     = 13;
    localparam int SUMMARY_BIT = 51;
    localparam int ENABLE_BIT  = 52;
    localparam int FREE_LO     = 53;
    localparam int FREE_N      = 3;
    localparam int MON_LO      = 56;
    localparam int MON_N       = 2;
    localparam int SCALAR_BIT  = 58;

    // Positions inside the data flag field
    localparam int F_SOFT  = 0;
    localparam int F_TIMER = 1;
    localparam int F_COND  = 2;
    localparam int F_DEC   = 3;
    localparam int F_TRUNC = 4;
    localparam int F_OR_A  = 5;
    localparam int F_DIVF  = 6;
    localparam int F_EXPO  = 7;
    localparam int F_UNDER = 8;
    localparam int F_OR_B  = 9;
    localparam int F_INDEF = 11;

    // Reset value and bits that software may load or alter
    localparam logic [63:0] FBR_RESET  = 64'h0000_0000_0000_0000;
    localparam logic [63:0] WRITE_MASK = 64'h03F0_FFF8_FFF8_0000;

    // Exponent limits, signed, after normalization
    localparam int EXP_W = 18;
    localparam logic signed [EXP_W-1:0] EXP_MAX_64 = 18'sh06FFF;
    localparam logic signed [EXP_W-1:0] EXP_MIN_64 = 18'sh39000;
    localparam logic signed [EXP_W-1:0] EXP_MAX_32 = 18'sh0006F;
    localparam logic signed [EXP_W-1:0] EXP_MIN_32 = 18'sh3FF90;

    // =================================================================
    // Carriers
    typedef struct packed {
        logic start;
        logic nop;
        logic may_set_free;
        logic done;
    } dfcr_instr_t;

    typedef struct packed {
        logic              permit;
        logic              scalar;
        logic [FREE_N-1:0] free_set;
        logic              timer;
        logic              cond_not_met;
        logic              no_match;
        logic              count_over;
        logic              dec_fault;
        logic              trunc;
        logic              int_div_zero;
        logic              range_over;
    } dfcr_event_t;

    typedef struct packed {
        logic                    valid;
        logic                    is_divide;
        logic                    half;
        logic                    coef_zero;
        logic                    divisor_mzero;
        logic                    opnd_indef;
        logic                    adjust_over;
        logic signed [EXP_W-1:0] exponent;
    } dfcr_fp_t;

    typedef struct packed {
        logic               div_fault;
        logic               exp_over;
        logic               under;
        logic               indef;
    } dfcr_fp_flags_t;

    typedef struct packed {
        logic               load;
        logic [DFCR_W-1:0]  load_data;
        logic               mask_op;
        logic [FIELD_N-1:0] mask_data;
        logic               alter;
        logic [5:0]         alter_bit;
        logic               alter_val;
    } dfcr_write_t;

    typedef struct packed {
        logic [DFCR_W-1:0] fbr;
        logic              branch;
        logic [MON_N-1:0]  count_gate;
    } dfcr_state_t;

endpackage

//--- logic/dfcr_fp_check.sv
`timescale 1ns/1ps
// =====================================================================
// Floating point result conditions
module dfcr_fp_check
    import dfcr_pkg::*;
(
    input  dfcr_fp_t       fp_in,
    output dfcr_fp_flags_t flags_out
);

    logic signed [EXP_W-1:0] hi;
    logic signed [EXP_W-1:0] lo;

    // Limits follow the operand width
    assign hi = fp_in.half ? EXP_MAX_32 : EXP_MAX_64;
    assign lo = fp_in.half ? EXP_MIN_32 : EXP_MIN_64;

    // Divide fault blocks overflow and underflow
    always_comb begin
        flags_out.div_fault = fp_in.valid && fp_in.is_divide
            && (fp_in.coef_zero || fp_in.divisor_mzero)
            && !fp_in.opnd_indef;
        flags_out.exp_over = fp_in.valid && !fp_in.opnd_indef
            && !flags_out.div_fault
            && ((fp_in.exponent > hi)
            || fp_in.adjust_over);
        flags_out.under = fp_in.valid && !flags_out.div_fault
            && !flags_out.exp_over
            && (fp_in.exponent < lo);
        flags_out.indef = flags_out.exp_over
            || flags_out.div_fault;
    end

endmodule

//--- logic/dfcr_field_sum.sv
`timescale 1ns/1ps
// =====================================================================
// Summary bits, products and branch summary
module dfcr_field_sum
    import dfcr_pkg::*;
(
    input  logic [FIELD_N-1:0] flags_in,
    input  logic [FIELD_N-1:0] mask_in,
    output logic [FIELD_N-1:0] flags_out,
    output logic [FIELD_N-1:0] prod_out,
    output logic               summary_out
);

    // Grouped flags are plain ORs of their members
    always_comb begin
        flags_out = flags_in;
        flags_out[F_OR_A] = |flags_in[F_TRUNC:F_COND];
        flags_out[F_OR_B] = |flags_in[F_UNDER:F_DIVF];
    end

    // One product per flag
    for (genvar i = 0; i < FIELD_N; i++) begin : g_prod
        assign prod_out[i] = flags_out[i] & mask_in[i];
    end

    // Free flags never feed this summary
    assign summary_out = |prod_out;

endmodule

//--- logic/dfcr_data_flag_unit.sv
`timescale 1ns/1ps
module dfcr_data_flag_unit
    import dfcr_pkg::*;
(
    input  logic              clk_sys_in,
    input  logic              reset_in,
    input  dfcr_instr_t       instr_in,
    input  dfcr_event_t       event_in,
    input  dfcr_fp_t          fp_in,
    input  dfcr_write_t       write_in,
    input  logic [MON_N-1:0]  count_cond_in,
    output logic [DFCR_W-1:0] flag_branch_register_out,
    output logic              branch_out,
    output logic [MON_N-1:0]  count_gate_out
);

    // =================================================================
    // Signals
    dfcr_state_t        st;
    dfcr_state_t        next_st;
    dfcr_fp_flags_t     fp_flags;
    logic [DFCR_W-1:0]  img;
    logic [FIELD_N-1:0] sets;
    logic [FIELD_N-1:0] field;
    logic [FIELD_N-1:0] prod;
    logic               summary;
    logic               free_clear;
    logic               fire;

    // =================================================================
    // Floating point result conditions
    dfcr_fp_check u_fp (
        .fp_in     (fp_in),
        .flags_out (fp_flags)
    );

    // Free flags clear at the start of a non-no-op instruction that may set them
    assign free_clear = instr_in.start && instr_in.may_set_free
        && !instr_in.nop;

    // =================================================================
    // Software writes applied to the held image
    always_comb begin
        img = st.fbr;
        if (write_in.load) begin
            img = write_in.load_data & WRITE_MASK;
            img[SCALAR_BIT] = 1'h0;
        end
        if (write_in.mask_op) begin
            img[MASK_LO +: FIELD_N] = write_in.mask_data;
            img[SCALAR_BIT] = 1'h0;
        end
        if (write_in.alter && WRITE_MASK[write_in.alter_bit]) begin
            img[write_in.alter_bit] = write_in.alter_val;
        end
        if (free_clear) begin
            img[FREE_LO +: FREE_N] = '0;
        end
    end

    // =================================================================
    // Hardware set requests, gated by the control vector
    always_comb begin
        sets = '0;
        sets[F_TIMER] = event_in.timer;
        sets[F_COND]  = event_in.cond_not_met
            || event_in.no_match
            || event_in.count_over;
        sets[F_DEC]   = event_in.dec_fault;
        // Both flags may set together on mixed faults
        sets[F_TRUNC] = event_in.trunc
            || event_in.int_div_zero
            || event_in.range_over;
        sets[F_DIVF]  = fp_flags.div_fault;
        sets[F_EXPO]  = fp_flags.exp_over;
        sets[F_UNDER] = fp_flags.under;
        sets[F_INDEF] = fp_flags.indef;
        if (!event_in.permit) begin
            sets = '0;
        end
    end

    // =================================================================
    // Grouped flags, products and summary
    dfcr_field_sum u_sum (
        .flags_in    (img[FLAG_LO +: FIELD_N] | sets),
        .mask_in     (img[MASK_LO +: FIELD_N]),
        .flags_out   (field),
        .prod_out    (prod),
        .summary_out (summary)
    );

    // Branch at instruction end when armed
    assign fire = instr_in.done && summary
        && img[ENABLE_BIT];

    // =================================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.fbr = img;
        // Sets win over any clear in the same cycle
        next_st.fbr[FLAG_LO +: FIELD_N] = field;
        next_st.fbr[PROD_LO +: FIELD_N] = prod;
        next_st.fbr[SUMMARY_BIT] = summary;
        if (event_in.permit) begin
            next_st.fbr[FREE_LO +: FREE_N] =
                img[FREE_LO +: FREE_N] | event_in.free_set;
        end
        if (event_in.scalar && (|sets)) begin
            next_st.fbr[SCALAR_BIT] = 1'h1;
        end
        next_st.branch = fire;
        if (fire) begin
            next_st.fbr[ENABLE_BIT] = 1'h0;
        end
        next_st.count_gate = img[MON_LO +: MON_N]
            & count_cond_in;
    end

    // =================================================================
    // State register
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            st <= '{fbr: FBR_RESET, branch: 1'h0, count_gate: '0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign flag_branch_register_out = st.fbr;
    assign branch_out = st.branch;
    assign count_gate_out = st.count_gate;

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    logic [DFCR_W-1:0] r;
    logic              no_wr;
    assign r = flag_branch_register_out;
    assign no_wr = !write_in.load && !write_in.alter;

    // Loaded context arms the soft interrupt
    sequence s_soft_armed;
        write_in.load && write_in.load_data[FLAG_LO + F_SOFT]
        && write_in.load_data[MASK_LO + F_SOFT]
        && write_in.load_data[ENABLE_BIT];
    endsequence

    // Instruction ends without a load or alter
    sequence s_quiet_done;
        instr_in.done && no_wr;
    endsequence

    property p_prod;
        r[PROD_LO +: FIELD_N] ==
            (r[FLAG_LO +: FIELD_N] & r[MASK_LO +: FIELD_N]);
    endproperty
    a_prod: assert property (p_prod)
        else $error("product field mismatch");

    property p_or_a;
        r[FLAG_LO + F_OR_A] ==
            (|r[FLAG_LO + F_TRUNC : FLAG_LO + F_COND]);
    endproperty
    a_or_a: assert property (p_or_a)
        else $error("bit 40 not OR of 37-39");

    property p_or_b;
        r[FLAG_LO + F_OR_B] ==
            (|r[FLAG_LO + F_UNDER : FLAG_LO + F_DIVF]);
    endproperty
    a_or_b: assert property (p_or_b)
        else $error("bit 44 not OR of 41-43");

    property p_summary_free;
        r[SUMMARY_BIT] == (|r[PROD_LO +: FIELD_N]);
    endproperty
    a_summary_free: assert property (p_summary_free)
        else $error("summary not from products");

    property p_branch;
        s_quiet_done and (r[SUMMARY_BIT] && r[ENABLE_BIT])
        |=> branch_out && !r[ENABLE_BIT];
    endproperty
    a_branch: assert property (p_branch)
        else $error("armed branch not taken");

    property p_no_branch;
        !r[ENABLE_BIT] && no_wr |=> !branch_out;
    endproperty
    a_no_branch: assert property (p_no_branch)
        else $error("branch without enable");

    property p_soft;
        s_soft_armed ##1 s_quiet_done |=> branch_out;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft interrupt did not branch");

    property p_free_clear;
        free_clear && no_wr && !(event_in.permit
            && (|event_in.free_set))
        |=> r[FREE_LO +: FREE_N] == 3'h0;
    endproperty
    a_free_clear: assert property (p_free_clear)
        else $error("free flags not cleared");

    property p_nop_keeps;
        instr_in.start && instr_in.nop && no_wr
        |=> (r[FREE_LO +: FREE_N]
            & $past(r[FREE_LO +: FREE_N]))
            == $past(r[FREE_LO +: FREE_N]);
    endproperty
    a_nop_keeps: assert property (p_nop_keeps)
        else $error("no-op cleared free flags");

    property p_sticky;
        no_wr |=> (r[FLAG_LO +: FIELD_N]
            & $past(r[FLAG_LO +: FIELD_N]))
            == $past(r[FLAG_LO +: FIELD_N]);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("data flag lost without write");

    property p_scalar_set;
        event_in.scalar && event_in.permit && (|sets)
        |=> r[SCALAR_BIT];
    endproperty
    a_scalar_set: assert property (p_scalar_set)
        else $error("scalar flag not set");

    property p_scalar_hold;
        r[SCALAR_BIT] && !write_in.load && !write_in.mask_op
        |=> r[SCALAR_BIT];
    endproperty
    a_scalar_hold: assert property (p_scalar_hold)
        else $error("scalar flag cleared wrongly");

    property p_ovf_indef;
        event_in.permit && fp_flags.exp_over
        |=> r[FLAG_LO + F_EXPO] && r[FLAG_LO + F_INDEF];
    endproperty
    a_ovf_indef: assert property (p_ovf_indef)
        else $error("overflow without indefinite");

    property p_divf_block;
        event_in.permit && fp_flags.div_fault && no_wr
        && !r[FLAG_LO + F_EXPO] && !r[FLAG_LO + F_UNDER]
        |=> r[FLAG_LO + F_DIVF] && !r[FLAG_LO + F_EXPO]
            && !r[FLAG_LO + F_UNDER];
    endproperty
    a_divf_block: assert property (p_divf_block)
        else $error("divide fault set over/underflow");

    property p_timer;
        event_in.permit && event_in.timer |=> r[FLAG_LO + F_TIMER];
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer flag not set");

    property p_count_gate;
        1'h1 |=> count_gate_out ==
            (r[MON_LO +: MON_N] & $past(count_cond_in));
    endproperty
    a_count_gate: assert property (p_count_gate)
        else $error("counter gate mismatch");

endmodule

//--- bench/dfcr_exec_model.sv
`timescale 1ns/1ps
// =====================================================================
// Execution unit model: reports phases and conditions as pulses
module dfcr_exec_model
    import dfcr_pkg::*;
(
    input  wire logic  clk_sys_in,
    output dfcr_instr_t instr_out,
    output dfcr_event_t event_out,
    output dfcr_fp_t    fp_out
);
    // Quiet between reports
    initial begin
        instr_out = '0;
        event_out = '0;
        fp_out    = '0;
    end

    // One-cycle report launched at the (d+1)th falling edge after the call
    task automatic issue(input dfcr_instr_t i, input dfcr_event_t e,
                         input dfcr_fp_t f, input int d);
        repeat (d) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        instr_out = i;
        event_out = e;
        fp_out    = f;
        @(negedge clk_sys_in);
        instr_out = '0;
        event_out = '0;
        fp_out    = '0;
    endtask
endmodule

//--- bench/data_flag_condition_register_tb.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the data flag unit
module data_flag_condition_register_tb
    import dfcr_pkg::*;
;
    logic              clk_sys_in;
    logic              reset_in;
    dfcr_instr_t       instr;
    dfcr_event_t       evt;
    dfcr_fp_t          fpr;
    dfcr_write_t       write_in;
    logic [MON_N-1:0]  cnt;
    logic [DFCR_W-1:0] fbr;
    logic              branch;
    logic [MON_N-1:0]  gate;
    int                n_mismatch = 0;
    int                compares = 0;
    // Float result table: controls, exponent, expected flag class
    logic [6:0]  fc[14] = '{7'h68, 7'h64, 7'h6A, 7'h40, 7'h40, 7'h50, 7'h50,
                            7'h41, 7'h42, 7'h40, 7'h40, 7'h50, 7'h50, 7'h64};
    logic [17:0] fx[14] = '{18'h00000, 18'h07000, 18'h00000, 18'h07000,
                            18'h06FFF, 18'h00070, 18'h0006F, 18'h00000,
                            18'h07000, 18'h38FFF, 18'h39000, 18'h3FF8F,
                            18'h3FF90, 18'h38FFF};
    logic [1:0]  fk[14] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0,
                            2'h2, 2'h0, 2'h3, 2'h0, 2'h3, 2'h0, 2'h1};

    // =================================================================
    // Design and partner
    dfcr_data_flag_unit u_dfcr_data_flag_unit (
        .clk_sys_in               (clk_sys_in),
        .reset_in                 (reset_in),
        .instr_in                 (instr),
        .event_in                 (evt),
        .fp_in                    (fpr),
        .write_in                 (write_in),
        .count_cond_in            (cnt),
        .flag_branch_register_out (fbr),
        .branch_out               (branch),
        .count_gate_out           (gate)
    );
    dfcr_exec_model u_dfcr_exec_model (
        .clk_sys_in (clk_sys_in),
        .instr_out  (instr),
        .event_out  (evt),
        .fp_out     (fpr)
    );

    // =================================================================
    // Helpers
    function automatic logic [63:0] b(input int n);
        return 64'h1 << n;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        compares++;
        if (seen !== want) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic wr(input dfcr_write_t w);
        @(negedge clk_sys_in);
        write_in = w;
        @(negedge clk_sys_in);
        write_in = '0;
    endtask

    task automatic ld(input logic [63:0] d);
        dfcr_write_t w;
        w = '0;
        w.load = 1'b1;
        w.load_data = d;
        wr(w);
    endtask

    task automatic alt(input int n, input logic v);
        dfcr_write_t w;
        w = '0;
        w.alter = 1'b1;
        w.alter_bit = 6'(n);
        w.alter_val = v;
        wr(w);
    endtask

    task automatic ins(input logic [3:0] i, input logic [12:0] e);
        u_dfcr_exec_model.issue(dfcr_instr_t'(i), dfcr_event_t'(e), '0, 0);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_load();
        check(fbr, FBR_RESET);
        check({63'h0, branch}, 64'h0);
        ld(64'hFFFF_FFFF_FFFF_FFFF);
        check(fbr, 64'h03F8_FFF8_FFF8_FFF8);
        ld(64'h0);
        check(fbr, 64'h0);
        alt(8, 1'b1);
        alt(58, 1'b1);
        check(fbr, 64'h0);
    endtask

    task automatic t_branch();
        ld(b(35) | b(19) | b(52));
        check(fbr, b(35) | b(19) | b(3) | b(51) | b(52));
        ins(4'h1, 13'h0);
        check({63'h0, branch}, 64'h1);
        check(fbr, b(35) | b(19) | b(3) | b(51));
        @(negedge clk_sys_in);
        check({63'h0, branch}, 64'h0);
        ld(b(19) | b(52));
        ins(4'h1, 13'h0);
        check({63'h0, branch}, 64'h0);
        alt(35, 1'b1);
        check(fbr, b(35) | b(19) | b(3) | b(51) | b(52));
        ins(4'h1, 13'h0);
        check({63'h0, branch}, 64'h1);
        ld(64'h0);
    endtask

    task automatic t_events();
        int f;
        for (int k = 0; k < 8; k++) begin
            f = (k < 3) ? 39 : (k == 3) ? 38 : (k < 7) ? 37 : 36;
            ins(4'h0, 13'h1000 | (13'h1 << k));
            check(fbr, b(f) | ((f == 36) ? 64'h0 : b(40)));
            ins(4'hA, 13'h0);
            check(fbr, b(f) | ((f == 36) ? 64'h0 : b(40)));
            ld(64'h0);
            ins(4'h0, 13'h1 << k);
            check(fbr, 64'h0);
        end
        ins(4'h0, 13'h100C);
        check(fbr, b(38) | b(39) | b(40));
        ld(64'h0);
    endtask

    task automatic t_scalar();
        dfcr_write_t w;
        ins(4'h0, 13'h1808);
        check(fbr, b(38) | b(40) | b(58));
        alt(38, 1'b0);
        check(fbr, b(58));
        w = '0;
        w.mask_op = 1'b1;
        w.mask_data = 13'h1FFF;
        wr(w);
        check(fbr, 64'hFFF8_0000);
        ins(4'h0, 13'h1808);
        ld(64'h0);
        check(fbr, 64'h0);
    endtask

    task automatic t_free();
        ld(b(52));
        ins(4'h0, 13'h1500);
        check(fbr, b(52) | b(53) | b(55));
        ins(4'h1, 13'h0);
        check({63'h0, branch}, 64'h0);
        ins(4'hE, 13'h0);
        check(fbr, b(52) | b(53) | b(55));
        ins(4'hA, 13'h0);
        check(fbr, b(52));
        ins(4'hA, 13'h1200);
        check(fbr, b(52) | b(54));
        ld(64'h0);
    endtask

    task automatic t_float();
        logic [63:0] want;
        logic [63:0] care;
        for (int i = 0; i < 14; i++) begin
            want = (fk[i] == 2'h1) ? (b(41) | b(44) | b(46)) :
                   (fk[i] == 2'h2) ? (b(42) | b(44) | b(46)) :
                   (fk[i] == 2'h3) ? (b(43) | b(44)) : 64'h0;
            care = (i == 8) ? b(42) : 64'hFFFF_FFFF_FFFF_FFFF;
            u_dfcr_exec_model.issue('0, dfcr_event_t'(13'h1000),
                                    dfcr_fp_t'({fc[i], fx[i]}), i % 3);
            check(fbr & care, want);
            ld(64'h0);
        end
    endtask

    task automatic t_gate();
        ld(b(56));
        @(negedge clk_sys_in);
        cnt = 2'b11;
        @(negedge clk_sys_in);
        check({62'h0, gate}, 64'h1);
        cnt = 2'b10;
        @(negedge clk_sys_in);
        check({62'h0, gate}, 64'h0);
        ld(b(57));
        @(negedge clk_sys_in);
        check({62'h0, gate}, 64'h2);
    endtask

    // =================================================================
    // Verdict and run control
    task automatic final_report();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        reset_in = 1'b1;
        write_in = '0;
        cnt = 2'b00;
        repeat (8) @(negedge clk_sys_in);
        reset_in = 1'b0;
        t_load();
        t_branch();
        t_events();
        t_scalar();
        t_free();
        t_float();
        t_gate();
        final_report();
    end
endmodule
